// [hw/mfd_pkg.sv]
package mfd_pkg;

  // Register offsets, byte addresses on the register port
  localparam logic [7:0]  MFD_OFS_CTRL_FAULT      = 8'he2;
  localparam logic [7:0]  MFD_OFS_DEBUG_A         = 8'hec;
  localparam logic [7:0]  MFD_OFS_DEBUG_B         = 8'hee;
  localparam logic [7:0]  MFD_OFS_CURRENT_GAINS   = 8'hf0;
  localparam logic [7:0]  MFD_OFS_SPEED_GAINS     = 8'hf2;
  localparam logic [7:0]  MFD_OFS_MONITOR_CTRL    = 8'hf4;

  // Reset values
  localparam logic [31:0] MFD_RST_CTRL_FAULT      = 32'h0000_0000;
  localparam logic [31:0] MFD_RST_DEBUG_A         = 32'h0000_0000;

  // Controller fault word bit positions
  localparam int          MFD_BIT_FAULT_SUMMARY   = 31;
  localparam int          MFD_BIT_PD_FREQ         = 29;
  localparam int          MFD_BIT_PD_INTERVAL     = 28;
  localparam int          MFD_BIT_BUS_ILIMIT      = 26;
  localparam int          MFD_BIT_EMF_MEAS        = 24;
  localparam int          MFD_BIT_ABNORMAL_SPEED_LOCK       = 23;
  localparam int          MFD_BIT_ABN_EMF         = 22;
  localparam int          MFD_BIT_MISSING_MOTOR   = 21;
  localparam int          MFD_BIT_ANY_LOCK        = 20;
  localparam int          MFD_BIT_LOCK_ILIMIT     = 19;
  localparam int          MFD_BIT_HARD_LOCK       = 18;
  localparam int          MFD_BIT_SUPPLY_LOW      = 17;
  localparam int          MFD_BIT_SUPPLY_HIGH     = 16;
  localparam int          MFD_BIT_SPEED_SAT       = 15;
  localparam int          MFD_BIT_CURRENT_SAT     = 14;
  localparam int          MFD_BIT_WATCHDOG        = 3;

  // Debug control word bit positions
  localparam int          MFD_BIT_SPEED_SRC       = 31;
  localparam int          MFD_DUTY_MSB            = 30;
  localparam int          MFD_DUTY_LSB            = 16;
  localparam int          MFD_BIT_OPEN_LOOP       = 15;
  localparam int          MFD_BIT_ALIGN_HOLD      = 14;
  localparam int          MFD_BIT_SLOW_HOLD       = 13;
  localparam int          MFD_BIT_PD_HOLD         = 12;
  localparam int          MFD_BIT_SD_HOLD         = 11;
  localparam int          MFD_BIT_ANGLE_SRC       = 10;

  // Field widths
  localparam int          MFD_DUTY_W              = 15;
  localparam int          MFD_ANGLE_W             = 5;

  // Startup method codes seen on the startup method input
  typedef enum logic [1:0] {
    MFD_START_ALIGN        = 2'h0,
    MFD_START_DOUBLE_ALIGN = 2'h1,
    MFD_START_SLOW_CYCLE   = 2'h2,
    MFD_START_POS_DETECT   = 2'h3
  } mfd_startup_type;

  // Fault levels from the controller core
  typedef struct packed {
    logic pulse_detect_freq_error;
    logic pulse_detect_interval_error;
    logic bus_current_limit_active;
    logic param_meas_emf_error;
    logic abnormal_speed_lock;
    logic abnormal_emf_lock;
    logic missing_motor_fault;
    logic lock_current_limit_fault;
    logic hard_lock_current_limit_fault;
    logic supply_low_fault;
    logic supply_high_fault;
    logic speed_loop_saturated;
    logic current_loop_saturated;
    logic watchdog_fault;
  } mfd_fault_in_type;

  // Decoded debug control word
  typedef struct packed {
    logic                  speed_source_select;
    logic [MFD_DUTY_W-1:0] duty_command;
    logic                  open_loop_force;
    logic                  align_hold;
    logic                  slow_cycle_hold;
    logic                  position_detect_hold;
    logic                  speed_detect_hold;
    logic                  align_angle_source_select;
  } mfd_debug_type;

endpackage

// [hw/mfd_regs.sv]
`timescale 1ns/1ns
module mfd_regs
  import mfd_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  input  wire logic [7:0]             reg_addr_i,
  input  wire logic                   reg_wr_i,
  input  wire logic [31:0]            reg_wdata_i,
  input  wire logic                   reg_rd_i,
  output logic      [31:0]            reg_rdata_o,
  output logic                        reg_rvalid_o,
  input  wire mfd_fault_in_type       faults_i,
  input  wire logic [MFD_DUTY_W-1:0]  analog_speed_i,
  input  wire mfd_startup_type        startup_method_i,
  input  wire logic                   initial_speed_detect_enable_i,
  input  wire logic [MFD_ANGLE_W-1:0] align_angle_i,
  input  wire logic [MFD_ANGLE_W-1:0] alternate_align_angle_i,
  output logic      [MFD_DUTY_W-1:0]  speed_command_o,
  output logic                        open_loop_force_o,
  output logic                        align_hold_o,
  output logic                        slow_cycle_hold_o,
  output logic                        position_detect_hold_o,
  output logic                        speed_detect_hold_o,
  output logic      [MFD_ANGLE_W-1:0] align_angle_o
);

  // Splits a written debug word into its fields
  function automatic mfd_debug_type unpack_debug(input logic [31:0] word);
    mfd_debug_type d;
    d.speed_source_select       = word[MFD_BIT_SPEED_SRC];
    d.duty_command              = word[MFD_DUTY_MSB:MFD_DUTY_LSB];
    d.open_loop_force           = word[MFD_BIT_OPEN_LOOP];
    d.align_hold                = word[MFD_BIT_ALIGN_HOLD];
    d.slow_cycle_hold           = word[MFD_BIT_SLOW_HOLD];
    d.position_detect_hold      = word[MFD_BIT_PD_HOLD];
    d.speed_detect_hold         = word[MFD_BIT_SD_HOLD];
    d.align_angle_source_select = word[MFD_BIT_ANGLE_SRC];
    return d;
  endfunction

  // Places the fault levels at their bit positions, summary on top
  function automatic logic [31:0] pack_faults(input mfd_fault_in_type f);
    logic [31:0] w;
    w                        = 32'h0000_0000;
    w[MFD_BIT_PD_FREQ]       = f.pulse_detect_freq_error;
    w[MFD_BIT_PD_INTERVAL]   = f.pulse_detect_interval_error;
    w[MFD_BIT_BUS_ILIMIT]    = f.bus_current_limit_active;
    w[MFD_BIT_EMF_MEAS]      = f.param_meas_emf_error;
    w[MFD_BIT_ABNORMAL_SPEED_LOCK]     = f.abnormal_speed_lock;
    w[MFD_BIT_ABN_EMF]       = f.abnormal_emf_lock;
    w[MFD_BIT_MISSING_MOTOR] = f.missing_motor_fault;
    w[MFD_BIT_ANY_LOCK]      = f.abnormal_speed_lock | f.abnormal_emf_lock | f.missing_motor_fault;
    w[MFD_BIT_LOCK_ILIMIT]   = f.lock_current_limit_fault;
    w[MFD_BIT_HARD_LOCK]     = f.hard_lock_current_limit_fault;
    w[MFD_BIT_SUPPLY_LOW]    = f.supply_low_fault;
    w[MFD_BIT_SUPPLY_HIGH]   = f.supply_high_fault;
    w[MFD_BIT_SPEED_SAT]     = f.speed_loop_saturated;
    w[MFD_BIT_CURRENT_SAT]   = f.current_loop_saturated;
    w[MFD_BIT_WATCHDOG]      = f.watchdog_fault;
    w[MFD_BIT_FAULT_SUMMARY] = |w[30:0];
    return w;
  endfunction

  logic [31:0]            status;
  logic [31:0]            next_status;
  mfd_debug_type          debug;
  mfd_debug_type          next_debug;
  logic [31:0]            next_rdata;
  logic                   next_rvalid;
  logic [MFD_DUTY_W-1:0]  next_speed_command;
  logic                   next_open_loop;
  logic                   next_align_hold;
  logic                   next_slow_hold;
  logic                   next_pd_hold;
  logic                   next_sd_hold;
  logic [MFD_ANGLE_W-1:0] next_align_angle;

  // Fault word follows the core's fault levels; bus writes never reach it
  always_comb
  begin
    next_status = pack_faults(faults_i);
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      status <= MFD_RST_CTRL_FAULT;
    else
      status <= next_status;
  end

  // Debug word takes only full writes at its own offset
  always_comb
  begin
    next_debug = debug;
    if (reg_wr_i && reg_addr_i == MFD_OFS_DEBUG_A)
      next_debug = unpack_debug(reg_wdata_i);
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      debug <= unpack_debug(MFD_RST_DEBUG_A);
    else
      debug <= next_debug;
  end

  // Read answer one cycle after the strobe; write-only and unmapped read zero
  always_comb
  begin
    next_rvalid = reg_rd_i;
    next_rdata  = 32'h0000_0000;
    if (reg_rd_i && reg_addr_i == MFD_OFS_CTRL_FAULT)
      next_rdata = status;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      reg_rdata_o  <= 32'h0000_0000;
      reg_rvalid_o <= 1'b0;
    end
    else
    begin
      reg_rdata_o  <= next_rdata;
      reg_rvalid_o <= next_rvalid;
    end
  end

  // Control outputs steered by the debug word
  always_comb
  begin
    next_speed_command = debug.speed_source_select ? debug.duty_command : analog_speed_i;
    next_open_loop     = debug.open_loop_force;
    next_align_hold    = debug.align_hold &&
                         (startup_method_i == MFD_START_ALIGN ||
                          startup_method_i == MFD_START_DOUBLE_ALIGN);
    next_slow_hold     = debug.slow_cycle_hold && startup_method_i == MFD_START_SLOW_CYCLE;
    next_pd_hold       = debug.position_detect_hold && startup_method_i == MFD_START_POS_DETECT;
    next_sd_hold       = debug.speed_detect_hold && initial_speed_detect_enable_i;
    next_align_angle   = debug.align_angle_source_select ? alternate_align_angle_i : align_angle_i;
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      speed_command_o        <= '0;
      open_loop_force_o      <= 1'b0;
      align_hold_o           <= 1'b0;
      slow_cycle_hold_o      <= 1'b0;
      position_detect_hold_o <= 1'b0;
      speed_detect_hold_o    <= 1'b0;
      align_angle_o          <= '0;
    end
    else
    begin
      speed_command_o        <= next_speed_command;
      open_loop_force_o      <= next_open_loop;
      align_hold_o           <= next_align_hold;
      slow_cycle_hold_o      <= next_slow_hold;
      position_detect_hold_o <= next_pd_hold;
      speed_detect_hold_o    <= next_sd_hold;
      align_angle_o          <= next_align_angle;
    end
  end

  // Summary bit follows any core fault level; the reset release edge starts no attempt
  property p_summary;
    @(posedge clk_i) disable iff (rst_i)
    !rst_i |=> status[MFD_BIT_FAULT_SUMMARY] == ($past(faults_i) != '0);
  endproperty
  a_summary: assert property (p_summary) else $error("summary bit not OR of flags");

  // Fault word read returns the stored word one cycle later
  property p_status_read;
    @(posedge clk_i) disable iff (rst_i)
    (!rst_i && reg_rd_i && reg_addr_i == MFD_OFS_CTRL_FAULT) |=> (reg_rvalid_o && reg_rdata_o == $past(status));
  endproperty
  a_status_read: assert property (p_status_read) else $error("fault word read wrong");

  // Position detection frequency and interval faults land in their own bits
  property p_pd_flags;
    @(posedge clk_i) disable iff (rst_i)
    !rst_i |=> (status[MFD_BIT_PD_FREQ] == $past(faults_i.pulse_detect_freq_error)) &&
        (status[MFD_BIT_PD_INTERVAL] == $past(faults_i.pulse_detect_interval_error));
  endproperty
  a_pd_flags: assert property (p_pd_flags) else $error("position detect flags wrong");

  property p_pd_interval;
    @(posedge clk_i) disable iff (rst_i)
    (!rst_i && faults_i.pulse_detect_interval_error && !faults_i.pulse_detect_freq_error)
      |=> (status[MFD_BIT_PD_INTERVAL] && !status[MFD_BIT_PD_FREQ]);
  endproperty
  a_pd_interval: assert property (p_pd_interval) else $error("interval flag not separate");

  // Bus current limit bit rises one cycle after its input level rises
  property p_bus_ilimit;
    @(posedge clk_i) disable iff (rst_i)
    (!rst_i && $rose(faults_i.bus_current_limit_active)) |=> $rose(status[MFD_BIT_BUS_ILIMIT]);
  endproperty
  a_bus_ilimit: assert property (p_bus_ilimit) else $error("bus current limit bit lags");

  property p_emf_meas;
    @(posedge clk_i) disable iff (rst_i)
    (!rst_i && faults_i.param_meas_emf_error) |=> status[MFD_BIT_EMF_MEAS] && status[MFD_BIT_FAULT_SUMMARY];
  endproperty
  a_emf_meas: assert property (p_emf_meas) else $error("emf measure flag missing");

  // Each lock cause has its own bit; abnormal speed, abnormal EMF and missing motor also raise the combined lock bit
  property p_abnormal_speed_lock;
    @(posedge clk_i) disable iff (rst_i)
    (!rst_i && faults_i.abnormal_speed_lock && !faults_i.abnormal_emf_lock)
      |=> (status[MFD_BIT_ABNORMAL_SPEED_LOCK] && !status[MFD_BIT_ABN_EMF]);
  endproperty
  a_abnormal_speed_lock: assert property (p_abnormal_speed_lock) else $error("abnormal speed flag wrong");

  property p_abn_emf;
    @(posedge clk_i) disable iff (rst_i)
    (!rst_i && faults_i.abnormal_emf_lock && !faults_i.abnormal_speed_lock)
      |=> (status[MFD_BIT_ABN_EMF] && !status[MFD_BIT_ABNORMAL_SPEED_LOCK]);
  endproperty
  a_abn_emf: assert property (p_abn_emf) else $error("abnormal emf flag wrong");

  property p_missing;
    @(posedge clk_i) disable iff (rst_i)
    (!rst_i && faults_i.missing_motor_fault) |=> status[MFD_BIT_MISSING_MOTOR];
  endproperty
  a_missing: assert property (p_missing) else $error("missing motor flag absent");

  property p_any_lock;
    @(posedge clk_i) disable iff (rst_i)
    !rst_i |=> status[MFD_BIT_ANY_LOCK] == ($past(faults_i.abnormal_speed_lock) |
                                            $past(faults_i.abnormal_emf_lock) |
                                            $past(faults_i.missing_motor_fault));
  endproperty
  a_any_lock: assert property (p_any_lock) else $error("combined lock bit wrong");

  property p_lock_limits;
    @(posedge clk_i) disable iff (rst_i)
    !rst_i |=> (status[MFD_BIT_LOCK_ILIMIT] == $past(faults_i.lock_current_limit_fault)) &&
        (status[MFD_BIT_HARD_LOCK] == $past(faults_i.hard_lock_current_limit_fault));
  endproperty
  a_lock_limits: assert property (p_lock_limits) else $error("lock current limit flags wrong");

  property p_supply;
    @(posedge clk_i) disable iff (rst_i)
    !rst_i |=> (status[MFD_BIT_SUPPLY_LOW] == $past(faults_i.supply_low_fault)) &&
        (status[MFD_BIT_SUPPLY_HIGH] == $past(faults_i.supply_high_fault));
  endproperty
  a_supply: assert property (p_supply) else $error("supply flags wrong");

  property p_saturation;
    @(posedge clk_i) disable iff (rst_i)
    !rst_i |=> (status[MFD_BIT_SPEED_SAT] == $past(faults_i.speed_loop_saturated)) &&
        (status[MFD_BIT_CURRENT_SAT] == $past(faults_i.current_loop_saturated));
  endproperty
  a_saturation: assert property (p_saturation) else $error("saturation flags wrong");

  property p_watchdog_reserved;
    @(posedge clk_i) disable iff (rst_i)
    !rst_i |=> (status[MFD_BIT_WATCHDOG] == $past(faults_i.watchdog_fault)) && status[30] == 1'b0 &&
        status[27] == 1'b0 && status[25] == 1'b0 && status[13:4] == 10'h000 && status[2:0] == 3'h0;
  endproperty
  a_watchdog_reserved: assert property (p_watchdog_reserved) else $error("watchdog or reserved bits wrong");

  // Speed source mux picks host duty or analog input
  property p_speed_src;
    @(posedge clk_i) disable iff (rst_i)
    !rst_i |=> speed_command_o == ($past(debug.speed_source_select) ? $past(debug.duty_command)
                                                                     : $past(analog_speed_i));
  endproperty
  a_speed_src: assert property (p_speed_src) else $error("speed command source wrong");

  // A written duty reaches the output two cycles later when the override is written set
  property p_duty_write;
    @(posedge clk_i) disable iff (rst_i)
    (!rst_i && reg_wr_i && reg_addr_i == MFD_OFS_DEBUG_A && reg_wdata_i[MFD_BIT_SPEED_SRC])
      |=> ##1 speed_command_o == $past(reg_wdata_i[MFD_DUTY_MSB:MFD_DUTY_LSB], 2);
  endproperty
  a_duty_write: assert property (p_duty_write) else $error("duty write not applied");

  property p_open_loop;
    @(posedge clk_i) disable iff (rst_i)
    (!rst_i && reg_wr_i && reg_addr_i == MFD_OFS_DEBUG_A)
      |=> ##1 open_loop_force_o == $past(reg_wdata_i[MFD_BIT_OPEN_LOOP], 2);
  endproperty
  a_open_loop: assert property (p_open_loop) else $error("open loop force wrong");

  property p_align_hold;
    @(posedge clk_i) disable iff (rst_i)
    !rst_i |=> align_hold_o == ($past(debug.align_hold) && ($past(startup_method_i) == MFD_START_ALIGN ||
                                                            $past(startup_method_i) == MFD_START_DOUBLE_ALIGN));
  endproperty
  a_align_hold: assert property (p_align_hold) else $error("align hold wrong");

  property p_slow_hold;
    @(posedge clk_i) disable iff (rst_i)
    !rst_i |=> slow_cycle_hold_o == ($past(debug.slow_cycle_hold) &&
                                     $past(startup_method_i) == MFD_START_SLOW_CYCLE);
  endproperty
  a_slow_hold: assert property (p_slow_hold) else $error("slow cycle hold wrong");

  property p_pd_hold;
    @(posedge clk_i) disable iff (rst_i)
    !rst_i |=> position_detect_hold_o == ($past(debug.position_detect_hold) &&
                                          $past(startup_method_i) == MFD_START_POS_DETECT);
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("position detect hold wrong");

  property p_sd_hold;
    @(posedge clk_i) disable iff (rst_i)
    !rst_i |=> speed_detect_hold_o == ($past(debug.speed_detect_hold) &&
                                       $past(initial_speed_detect_enable_i));
  endproperty
  a_sd_hold: assert property (p_sd_hold) else $error("speed detect hold wrong");

  property p_angle;
    @(posedge clk_i) disable iff (rst_i)
    !rst_i |=> align_angle_o == ($past(debug.align_angle_source_select) ? $past(alternate_align_angle_i)
                                                                        : $past(align_angle_i));
  endproperty
  a_angle: assert property (p_angle) else $error("align angle source wrong");

  property p_debug_wo;
    @(posedge clk_i) disable iff (rst_i)
    (!rst_i && reg_rd_i && reg_addr_i == MFD_OFS_DEBUG_A) |=> (reg_rvalid_o && reg_rdata_o == 32'h0000_0000);
  endproperty
  a_debug_wo: assert property (p_debug_wo) else $error("debug word readable");

  property p_status_write_ignored;
    @(posedge clk_i) disable iff (rst_i)
    (!rst_i && reg_wr_i && reg_addr_i == MFD_OFS_CTRL_FAULT && reg_wdata_i != 32'h0000_0000 &&
     faults_i == '0) |=> status == 32'h0000_0000;
  endproperty
  a_status_write_ignored: assert property (p_status_write_ignored) else $error("fault word took a write");

  // Read port is quiet between answers: no stray valid, data parked at zero
  property p_rvalid_only;
    @(posedge clk_i) disable iff (rst_i)
    (!rst_i && !reg_rd_i) |=> !reg_rvalid_o;
  endproperty
  a_rvalid_only: assert property (p_rvalid_only) else $error("read answer without a strobe");

  property p_rdata_idle;
    @(posedge clk_i) disable iff (rst_i)
    !reg_rvalid_o |-> reg_rdata_o == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not parked at zero");

endmodule // mfd_regs

// [testbench/mfd_host.sv]
`timescale 1ns/1ns
module mfd_host
(
  input  wire logic        clk_i,
  input  wire logic [31:0] rdata_i,
  input  wire logic        rvalid_i,
  output logic      [7:0]  addr_o,
  output logic             wr_o,
  output logic      [31:0] wdata_o,
  output logic             rd_o
);
  // Idle bus at time zero
  initial
  begin
    addr_o  = 8'h00;
    wr_o    = 1'b0;
    wdata_o = 32'h0000_0000;
    rd_o    = 1'b0;
  end

  // One write strobe; released lines then show inverted values, not the last ones
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_o  <= a;
    wdata_o <= d;
    wr_o    <= 1'b1;
    @(posedge clk_i);
    wr_o    <= 1'b0;
    addr_o  <= ~a;
    wdata_o <= ~d;
  endtask

  // One read strobe; the answer stands for one cycle after the taking edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic v);
    @(posedge clk_i);
    addr_o <= a;
    rd_o   <= 1'b1;
    @(posedge clk_i);
    rd_o   <= 1'b0;
    addr_o <= ~a;
    @(negedge clk_i);
    v = rvalid_i;
    d = rdata_i;
  endtask
endmodule // mfd_host

// [testbench/testbench.sv]
`timescale 1ns/1ns
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; $display("BAD %s exp %h got %h", n, e, g); end end
module testbench
  import mfd_pkg::*;
;
  logic             clk_i = 1'b0;
  logic             rst_i = 1'b1;
  logic [7:0]       reg_addr;
  logic             reg_wr, reg_rd, reg_rvalid;
  logic [31:0]      reg_wdata, reg_rdata;
  mfd_fault_in_type faults = '0;
  mfd_startup_type  startup = MFD_START_ALIGN;
  logic             initial_speed_detect_enable = 1'b1;
  logic [14:0]      analog_speed = 15'h1234;
  logic [14:0]      speed_command;
  logic [4:0]       angle = 5'h03, alt_angle = 5'h1c, angle_out;
  logic             open_loop, align_hold, slow_hold, pd_hold, sd_hold;
  int               n_fail = 0, n_checks = 0;
  // Fault inputs beside the fault word they should read back as
  logic [45:0]      rows [16] = '{
    {14'h2000, 32'ha000_0000}, {14'h1000, 32'h9000_0000}, {14'h0800, 32'h8400_0000}, {14'h0400, 32'h8100_0000},
    {14'h0200, 32'h8090_0000}, {14'h0100, 32'h8050_0000}, {14'h0080, 32'h8030_0000}, {14'h0040, 32'h8008_0000},
    {14'h0020, 32'h8004_0000}, {14'h0010, 32'h8002_0000}, {14'h0008, 32'h8001_0000}, {14'h0004, 32'h8000_8000},
    {14'h0002, 32'h8000_4000}, {14'h0001, 32'h8000_0008}, {14'h3fff, 32'hb5ff_c008}, {14'h0000, 32'h0000_0000}};

  always #10 clk_i = ~clk_i;

  mfd_host host (.clk_i(clk_i), .rdata_i(reg_rdata), .rvalid_i(reg_rvalid), .addr_o(reg_addr),
                 .wr_o(reg_wr), .wdata_o(reg_wdata), .rd_o(reg_rd));

  mfd_regs dut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr),
                .reg_wdata_i(reg_wdata), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata), .reg_rvalid_o(reg_rvalid),
                .faults_i(faults), .analog_speed_i(analog_speed), .startup_method_i(startup),
                .initial_speed_detect_enable_i(initial_speed_detect_enable), .align_angle_i(angle), .alternate_align_angle_i(alt_angle),
                .speed_command_o(speed_command), .open_loop_force_o(open_loop), .align_hold_o(align_hold),
                .slow_cycle_hold_o(slow_hold), .position_detect_hold_o(pd_hold), .speed_detect_hold_o(sd_hold),
                .align_angle_o(angle_out));

  // Read one word and compare the answer and its valid pulse
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] d;
    logic        v;
    host.rd(a, d, v);
    `CHK("rvalid", 1'b1, v)
    `CHK(n, e, d)
  endtask

  // Let a register write or input change reach the outputs
  task automatic settle();
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial
  begin
    #100000;
    n_fail++;
    test_done();
  end

  // Main sequence
  initial
  begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    settle();
    rchk(MFD_OFS_CTRL_FAULT, 32'h0, "fault_reset");
    `CHK("speed_analog", 15'h1234, speed_command)
    `CHK("open_loop_rst", 1'b0, open_loop)
    `CHK("angle_normal", 5'h03, angle_out)
    $display("test reset done");
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk_i);
      faults <= rows[i][45:32];
      rchk(MFD_OFS_CTRL_FAULT, rows[i][31:0], "fault_word");
    end
    $display("test fault table done");
    host.wr(MFD_OFS_DEBUG_A, 32'h8005_fc00);
    settle();
    `CHK("speed_digital", 15'h0005, speed_command)
    `CHK("open_loop", 1'b1, open_loop)
    `CHK("angle_alt", 5'h1c, angle_out)
    for (int m = 0; m < 4; m++)
    begin
      @(posedge clk_i);
      startup <= mfd_startup_type'(m);
      initial_speed_detect_enable  <= m[0];
      settle();
      `CHK("align_hold", (m < 2), align_hold)
      `CHK("slow_hold", (m == 2), slow_hold)
      `CHK("pd_hold", (m == 3), pd_hold)
      `CHK("sd_hold", m[0], sd_hold)
    end
    $display("test debug word done");
    rchk(MFD_OFS_DEBUG_A, 32'h0, "debug_read");
    rchk(MFD_OFS_MONITOR_CTRL, 32'h0, "unmapped_read");
    host.wr(MFD_OFS_DEBUG_A, 32'h0000_0000);
    settle();
    `CHK("speed_back", 15'h1234, speed_command)
    `CHK("open_loop_off", 1'b0, open_loop)
    `CHK("angle_back", 5'h03, angle_out)
    `CHK("pd_hold_off", 1'b0, pd_hold)
    `CHK("sd_hold_off", 1'b0, sd_hold)
    host.wr(MFD_OFS_CTRL_FAULT, 32'hffff_ffff);
    rchk(MFD_OFS_CTRL_FAULT, 32'h0, "fault_wr_idle");
    @(posedge clk_i);
    faults <= 14'h3fff;
    host.wr(MFD_OFS_CTRL_FAULT, 32'h0000_0000);
    rchk(MFD_OFS_CTRL_FAULT, 32'hb5ff_c008, "fault_after_wr");
    $display("test refusals done");
    host.wr(MFD_OFS_DEBUG_A, 32'hffff_8000);
    settle();
    `CHK("speed_full", 15'h7fff, speed_command)
    `CHK("open_pre_rst", 1'b1, open_loop)
    @(posedge clk_i);
    rst_i <= 1'b1;
    @(negedge clk_i);
    `CHK("speed_in_rst", 15'h0000, speed_command)
    `CHK("open_in_rst", 1'b0, open_loop)
    @(posedge clk_i);
    rst_i <= 1'b0;
    settle();
    `CHK("open_after_rst", 1'b0, open_loop)
    `CHK("speed_after_rst", 15'h1234, speed_command)
    $display("test second reset done");
    test_done();
  end
endmodule // testbench
